/* File: rtl/scsd_clock_ctrl.sv */
// system clock source select, power-of-two divider and internal oscillator control
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ns
`include "scsd_params.svh"
module scsd_clock_ctrl
#(
	parameter logic [6:0] CAL_FACTORY = `SCSD_CAL_FACTORY // trimmed value, arbitrary default
)
(
	input  wire logic                     mclk,             // 25 MHz bus clock
	input  wire logic                     rstn,             // async reset, active low
	input  wire scsd_pkg::scsd_req_s      avs_req,          // avalon read/write/address/writedata
	output logic [31:0]                   avs_readdata,     // avalon read data
	output logic                          avs_waitrequest,  // avalon wait request
	input  wire scsd_pkg::scsd_ticks_s    osc_ticks,        // oscillator period pulses
	input  wire logic                     int_osc_settled,  // analog: internal osc at frequency
	input  wire logic                     ext_osc_stable,   // analog: external osc stable
	output logic                          sysclk_tick,      // one pulse per system clock period
	output scsd_pkg::scsd_src_e           active_src,       // oscillator now feeding the system
	output logic                          internal_osc_on,  // enable to internal oscillator
	output logic                          spread_dither_on, // dithering enable to oscillator
	output logic [6:0]                    osc_trim,         // calibration code to oscillator
	output scsd_pkg::scsd_xmode_e         ext_mode,         // external oscillator mode
	output logic [2:0]                    ext_bias          // external oscillator bias code
);
	import scsd_pkg::*;

	logic [2:0]  src_fld_r;
	logic [2:0]  div_fld_r;
	logic [2:0]  div_act_r;
	logic        div_pend_r;
	logic [6:0]  pre_cnt_r;
	scsd_src_e   src_act_r;
	scsd_src_e   src_req_r;
	logic        seen_old_r;
	logic        seen_new_r;
	logic        osc_on_r;
	logic        freq_ok_r;
	logic        spread_r;
	logic [6:0]  cal_r;
	logic [2:0]  xmode_r;
	logic [2:0]  xbias_r;
	logic        xvalid_r;
	logic        sys_tick_r;
	logic        wait_r;
	logic [31:0] rdata_r;
	logic        req;
	logic        ack_wr;
	logic [7:0]  idx;
	logic        src_tick;
	logic        old_tick;
	logic        new_tick;

	// tick of one oscillator selected by source code
	function automatic logic tick_of(input logic [2:0] code, input scsd_ticks_s t);
		case (code)
			SCSD_SRC_INT: tick_of = t.int_osc;
			SCSD_SRC_EXT: tick_of = t.ext_osc;
			SCSD_SRC_RTC: tick_of = t.rtc_osc;
			SCSD_SRC_LP:  tick_of = t.lp_osc;
			default:      tick_of = 1'b0;
		endcase
	endfunction : tick_of

	// low-bit mask for a divide by two to the code
	function automatic logic [6:0] div_mask(input logic [2:0] code);
		div_mask = 7'(8'hFF >> (4'h8 - {1'b0, code}));
	endfunction : div_mask

	// source codes with an oscillator behind them
	function automatic logic src_ok(input logic [2:0] code);
		src_ok = (code == SCSD_SRC_INT) || (code == SCSD_SRC_EXT) ||
			(code == SCSD_SRC_RTC) || (code == SCSD_SRC_LP);
	endfunction : src_ok

	// bus decode; registers sit at four times their index, one byte in the low lane
	assign req      = avs_req.read | avs_req.write;
	assign ack_wr   = avs_req.write & ~wait_r;
	assign idx      = avs_req.address[`SCSD_ADDR_W-1:2];
	assign src_tick = tick_of(src_act_r, osc_ticks);
	assign old_tick = src_tick;
	assign new_tick = tick_of(src_req_r, osc_ticks);

	// one wait state per access, released for exactly one cycle
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			wait_r <= 1'b1;
		else
			wait_r <= ~(req & wait_r);
	end

	// read data captured as waitrequest drops; unmapped reads give zero
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			rdata_r <= 32'h0000_0000;
		else if (avs_req.read & wait_r)
		begin
			case (idx)
				`SCSD_IDX_SEL:      rdata_r <= {24'h0, ~div_pend_r, div_fld_r, 1'b0, src_fld_r};
				`SCSD_IDX_OSC_CTRL: rdata_r <= {24'h0, osc_on_r, freq_ok_r, `SCSD_OSC_RSVD_VAL};
				`SCSD_IDX_OSC_CAL:  rdata_r <= {24'h0, spread_r, cal_r};
				`SCSD_IDX_EXT_CTRL: rdata_r <= {24'h0, xvalid_r, xmode_r, 1'b0, xbias_r};
				default:            rdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// select register fields; reset picks low power oscillator, divide by eight
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			src_fld_r <= 3'(`SCSD_SEL_RESET & 8'h07);
			div_fld_r <= 3'((`SCSD_SEL_RESET >> 4) & 8'h07);
		end
		else if (ack_wr && idx == `SCSD_IDX_SEL)
		begin
			src_fld_r <= avs_req.writedata[2:0];
			div_fld_r <= avs_req.writedata[6:4];
		end
	end

	// a new ratio waits for the 128-tick prescaler wrap, so no short system period appears
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			div_act_r  <= 3'((`SCSD_SEL_RESET >> 4) & 8'h07);
			div_pend_r <= 1'b1;
		end
		else if (div_pend_r && src_tick && pre_cnt_r == `SCSD_PRESCALE_MAX)
		begin
			// a write landing on the wrap is applied at once, so the newly written ratio is never left unapplied
			div_act_r  <= (ack_wr && idx == `SCSD_IDX_SEL) ? avs_req.writedata[6:4] : div_fld_r;
			div_pend_r <= 1'b0;
		end
		else if (ack_wr && idx == `SCSD_IDX_SEL && avs_req.writedata[6:4] != div_act_r)
			div_pend_r <= 1'b1;
	end

	// prescaler counts undivided source periods and emits the divided tick
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			pre_cnt_r  <= 7'h00;
			sys_tick_r <= 1'b0;
		end
		else
		begin
			if (src_tick)
				pre_cnt_r <= pre_cnt_r + 7'h01;
			sys_tick_r <= src_tick && ((pre_cnt_r & div_mask(div_act_r)) == div_mask(div_act_r));
		end
	end

	// source switch: wait for one period of both old and new oscillators
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			src_act_r  <= SCSD_SRC_LP;
			src_req_r  <= SCSD_SRC_LP;
			seen_old_r <= 1'b0;
			seen_new_r <= 1'b0;
		end
		else if (ack_wr && idx == `SCSD_IDX_SEL && src_ok(avs_req.writedata[2:0]))
		begin
			src_req_r  <= scsd_src_e'(avs_req.writedata[2:0]);
			seen_old_r <= 1'b0;
			seen_new_r <= 1'b0;
		end
		else if (src_req_r != src_act_r)
		begin
			if (seen_old_r && seen_new_r)
				src_act_r <= src_req_r;
			if (old_tick)
				seen_old_r <= 1'b1;
			if (new_tick)
				seen_new_r <= 1'b1;
		end
	end

	// internal oscillator enable and frequency flag; reserved bits are not stored
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			osc_on_r  <= 1'(`SCSD_OSC_CTRL_RESET >> `SCSD_BIT_OSC_ON);
			freq_ok_r <= 1'b0;
		end
		else
		begin
			if (ack_wr && idx == `SCSD_IDX_OSC_CTRL)
				osc_on_r <= avs_req.writedata[`SCSD_BIT_OSC_ON];
			freq_ok_r <= osc_on_r & int_osc_settled;
		end
	end

	// calibration and spread enable; trim comes up at the factory value
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			spread_r <= 1'b0;
			cal_r    <= CAL_FACTORY;
		end
		else if (ack_wr && idx == `SCSD_IDX_OSC_CAL)
		begin
			spread_r <= avs_req.writedata[`SCSD_BIT_SPREAD];
			cal_r    <= avs_req.writedata[6:0];
		end
	end

	// external oscillator mode, bias and valid flag
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			xmode_r  <= 3'h0;
			xbias_r  <= 3'h0;
			xvalid_r <= 1'b0;
		end
		else
		begin
			if (ack_wr && idx == `SCSD_IDX_EXT_CTRL)
			begin
				xmode_r <= avs_req.writedata[6:4];
				xbias_r <= avs_req.writedata[2:0];
			end
			// cmos input has no detector, so valid stays low there and when disabled
			xvalid_r <= ext_osc_stable && (xmode_r == SCSD_XM_RC || xmode_r == SCSD_XM_CAP ||
				xmode_r == SCSD_XM_OSC_PIN_B);
		end
	end

	assign avs_readdata     = rdata_r;
	assign avs_waitrequest  = wait_r;
	assign sysclk_tick      = sys_tick_r;
	assign active_src       = src_act_r;
	assign internal_osc_on  = osc_on_r;
	assign spread_dither_on = spread_r;
	assign osc_trim         = cal_r;
	assign ext_mode         = scsd_xmode_e'(xmode_r);
	assign ext_bias         = xbias_r;

	// source ticks seen while a ratio is pending, for the apply bound
	logic [8:0] pend_ticks_r;
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			pend_ticks_r <= 9'h000;
		else if (!div_pend_r)
			pend_ticks_r <= 9'h000;
		else if (src_tick)
			pend_ticks_r <= pend_ticks_r + 9'h001;
	end

	property p_src_valid;
		@(posedge mclk) disable iff (!rstn) src_ok(src_act_r);
	endproperty
	a_src_valid: assert property (p_src_valid) else $error("active source code reserved");

	property p_div_tick;
		@(posedge mclk) disable iff (!rstn)
			sys_tick_r |-> $past(src_tick) && (($past(pre_cnt_r) & div_mask($past(div_act_r))) == div_mask($past(div_act_r)));
	endproperty
	a_div_tick: assert property (p_div_tick) else $error("system tick off the divide boundary");

	property p_apply_bound;
		@(posedge mclk) disable iff (!rstn) pend_ticks_r <= 9'(`SCSD_APPLY_MAX_TICKS);
	endproperty
	a_apply_bound: assert property (p_apply_bound) else $error("divide ratio not applied in 128 ticks");

	property p_ready_apply;
		@(posedge mclk) disable iff (!rstn)
			$fell(div_pend_r) |-> div_act_r == div_fld_r && $past(pre_cnt_r) == `SCSD_PRESCALE_MAX;
	endproperty
	a_ready_apply: assert property (p_ready_apply) else $error("ready rose without applying the ratio");

	property p_switch;
		@(posedge mclk) disable iff (!rstn)
			$changed(src_act_r) |-> $past(seen_old_r) && $past(seen_new_r);
	endproperty
	a_switch: assert property (p_switch) else $error("source switched before both periods");

	property p_sel_bit3;
		@(posedge mclk) disable iff (!rstn)
			avs_req.read && wait_r && idx == `SCSD_IDX_SEL |=> rdata_r[`SCSD_BIT_UNUSED] == 1'b0;
	endproperty
	a_sel_bit3: assert property (p_sel_bit3) else $error("unused select bit read as one");

	property p_osc_rsvd;
		@(posedge mclk) disable iff (!rstn)
			avs_req.read && wait_r && idx == `SCSD_IDX_OSC_CTRL |=> rdata_r[5:0] == `SCSD_OSC_RSVD_VAL;
	endproperty
	a_osc_rsvd: assert property (p_osc_rsvd) else $error("reserved oscillator bits wrong");

	property p_freq_ok;
		@(posedge mclk) disable iff (!rstn) freq_ok_r |-> $past(osc_on_r) && $past(int_osc_settled);
	endproperty
	a_freq_ok: assert property (p_freq_ok) else $error("frequency flag set with oscillator off");

	property p_spread;
		@(posedge mclk) disable iff (!rstn)
			ack_wr && idx == `SCSD_IDX_OSC_CAL |=> spread_r == $past(avs_req.writedata[7]);
	endproperty
	a_spread: assert property (p_spread) else $error("spread enable not written");

	property p_cmos_valid;
		@(posedge mclk) disable iff (!rstn)
			(xmode_r == SCSD_XM_CMOS || xmode_r == SCSD_XM_CMOS2) |=> !xvalid_r;
	endproperty
	a_cmos_valid: assert property (p_cmos_valid) else $error("external valid set in cmos mode");

endmodule : scsd_clock_ctrl

/* File: common/scsd_params.svh */
// offsets, field positions, reset values and timing counts of the clock select block
`ifndef SCSD_PARAMS_SVH
`define SCSD_PARAMS_SVH
`define SCSD_IDX_EXT_CTRL   8'hB1
`define SCSD_IDX_SEL        8'hA9
`define SCSD_IDX_OSC_CTRL   8'hB2
`define SCSD_IDX_OSC_CAL    8'hB3
`define SCSD_ADDR_W         10
`define SCSD_SEL_RESET      8'h34
`define SCSD_OSC_CTRL_RESET 8'h0F
`define SCSD_OSC_RSVD_VAL   6'h0F
`define SCSD_EXT_RESET      8'h00
`define SCSD_CAL_FACTORY    7'h40
`define SCSD_BIT_READY      7
`define SCSD_BIT_UNUSED     3
`define SCSD_BIT_OSC_ON     7
`define SCSD_BIT_FREQ_OK    6
`define SCSD_BIT_SPREAD     7
`define SCSD_BIT_EXT_VALID  7
`define SCSD_PRESCALE_MAX   7'h7F
`define SCSD_APPLY_MAX_TICKS 128
`endif

/* File: common/scsd_pkg.sv */
// types of the clock select and divider block
`include "scsd_params.svh"
package scsd_pkg;
	typedef enum logic [2:0] {
		SCSD_SRC_INT = 3'h0,
		SCSD_SRC_EXT = 3'h1,
		SCSD_SRC_RTC = 3'h3,
		SCSD_SRC_LP  = 3'h4
	} scsd_src_e;
	typedef enum logic [2:0] {
		SCSD_XM_OFF0   = 3'h0,
		SCSD_XM_OFF1   = 3'h1,
		SCSD_XM_CMOS   = 3'h2,
		SCSD_XM_CMOS2  = 3'h3,
		SCSD_XM_RC     = 3'h4,
		SCSD_XM_CAP    = 3'h5,
		SCSD_XM_OSC_PIN_B  = 3'h6,
		SCSD_XM_RSVD   = 3'h7
	} scsd_xmode_e;
	// one mclk-wide pulse per period of each oscillator
	typedef struct packed {
		logic int_osc;
		logic ext_osc;
		logic rtc_osc;
		logic lp_osc;
	} scsd_ticks_s;
	typedef struct packed {
		logic                      read;
		logic                      write;
		logic [`SCSD_ADDR_W-1:0]   address;
		logic [31:0]               writedata;
	} scsd_req_s;
endpackage : scsd_pkg

/* File: tb/tb_system_clock_select_divider.sv */
// self-checking bench of the clock select, divider and oscillator control block
`timescale 1ns/1ns
`include "scsd_params.svh"
module tb_system_clock_select_divider;
	import scsd_pkg::*;
	typedef struct packed {logic chk; logic [31:0] val;} scsd_tbexp_s;
	logic          mclk = 0;
	logic          rstn = 0;
	scsd_req_s     avs_req = '0;
	logic [31:0]   avs_readdata;
	logic          avs_waitrequest;
	scsd_ticks_s   osc_ticks = '0;
	logic          int_osc_settled = 0;
	logic          ext_osc_stable = 0;
	logic          sysclk_tick;
	scsd_src_e     active_src;
	logic          internal_osc_on;
	logic          spread_dither_on;
	logic [6:0]    osc_trim;
	scsd_xmode_e   ext_mode;
	logic [2:0]    ext_bias;
	scsd_tbexp_s   expq[$];
	scsd_tbexp_s   e;
	integer        seed = 32'he6aef434;
	int            fails = 0;
	int            checks_done = 0;
	int            cyc = 0;
	int            ticks = 0;
	int            mcnt = 0;
	int            ratio = 1;
	logic          meas = 0;
	logic          mvalid = 0;
	logic [31:0]   rd;
	int            t0;
	int            n;
	logic [2:0]    srcs [5] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h4};
	logic [2:0]    want;
	scsd_clock_ctrl uut (.mclk(mclk), .rstn(rstn), .avs_req(avs_req), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .osc_ticks(osc_ticks), .int_osc_settled(int_osc_settled),
		.ext_osc_stable(ext_osc_stable), .sysclk_tick(sysclk_tick), .active_src(active_src),
		.internal_osc_on(internal_osc_on), .spread_dither_on(spread_dither_on), .osc_trim(osc_trim),
		.ext_mode(ext_mode), .ext_bias(ext_bias));
	always #20 mclk = ~mclk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wrap_up;
		if (fails == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	// one avalon transfer, held until waitrequest is sampled low
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] q);
		@(posedge mclk);
		avs_req <= '{read: !wr, write: wr, address: {idx, 2'b00}, writedata: {24'h0, d}};
		do
			@(posedge mclk);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_req.read <= 0;
		avs_req.write <= 0;
	endtask : xfer
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] q;
		xfer(1, idx, d, q);
	endtask : wr
	task automatic rdx(input logic [7:0] idx, input logic c, input logic [31:0] x);
		expq.push_back('{chk: c, val: x});
		xfer(0, idx, 8'h00, rd);
	endtask : rdx
	// poll the applied flag, counting source ticks spent waiting
	task automatic wait_ready;
		t0 = ticks;
		rd = 0;
		for (int k = 0; k < 500 && rd[7] !== 1'b1; k++)
			rdx(`SCSD_IDX_SEL, 0, 0);
		// the write-edge tick and up to three ticks of polling lag come on top of the bound
		check(ticks - t0 <= `SCSD_APPLY_MAX_TICKS + 4, 1);
	endtask : wait_ready
	// random oscillator pulses, about one in four cycles each
	always @(posedge mclk)
	begin
		osc_ticks <= 4'($random(seed) & $random(seed));
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			fails++;
			wrap_up;
		end
	end
	// read data checked against the oldest note
	always @(posedge mclk)
		if (avs_req.read && avs_waitrequest === 1'b0)
		begin
			e = expq.pop_front();
			if (e.chk)
				check(avs_readdata, e.val);
		end
	// source ticks between system clock pulses give the division ratio
	always @(posedge mclk)
	begin
		ticks <= ticks + osc_ticks.lp_osc;
		if (sysclk_tick === 1'b1)
		begin
			if (meas && mvalid)
				check(mcnt, ratio);
			mcnt <= osc_ticks.lp_osc;
			mvalid <= meas;
		end
		else
			mcnt <= mcnt + osc_ticks.lp_osc;
	end
	initial
	begin
		repeat (4) @(posedge mclk);
		rstn <= 1;
		check({internal_osc_on, active_src, osc_trim}, {1'b0, SCSD_SRC_LP, 7'h40});
		rdx(`SCSD_IDX_SEL, 1, 32'h34);
		rdx(`SCSD_IDX_OSC_CTRL, 1, 32'h0F);
		rdx(`SCSD_IDX_OSC_CAL, 1, 32'h40);
		// every divide code on the low power source, bit 3 always written low
		for (int d = 0; d < 8; d++)
		begin
			meas = 0;
			wr(`SCSD_IDX_SEL, {1'b0, 3'(d), 1'b0, 3'h4});
			wait_ready;
			rdx(`SCSD_IDX_SEL, 1, {24'h0, 1'b1, 3'(d), 4'h4});
			ratio = 1 << d;
			meas = 1;
			n = 0;
			for (int k = 0; k < 3000 && n < 3; k++)
			begin
				@(posedge mclk);
				n += (sysclk_tick === 1'b1);
			end
		end
		meas = 0;
		// divide by one settled first, as before any sleep entry, so ready stays high below
		wr(`SCSD_IDX_SEL, 8'h04);
		wait_ready;
		// capacitor mode started as for rc: configure, enable, poll valid, only then switch
		ext_osc_stable <= 1;
		wr(`SCSD_IDX_EXT_CTRL, 8'h53);
		rd = 0;
		for (int k = 0; k < 50 && rd[7] !== 1'b1; k++)
			rdx(`SCSD_IDX_EXT_CTRL, 0, 0);
		check(rd, 32'hD3);
		// on-the-fly source switch, reserved code stored but ignored
		for (int i = 0; i < 5; i++)
		begin
			// fast sources want the flash one-shot bypassed, which is set outside this block
			wr(`SCSD_IDX_SEL, {5'h00, srcs[i]});
			want = (srcs[i] == 3'h2) ? 3'(SCSD_SRC_RTC) : srcs[i];
			for (int k = 0; k < 200 && active_src !== want; k++)
				@(posedge mclk);
			check(active_src, want);
			rdx(`SCSD_IDX_SEL, 1, {24'h0, 1'b1, 4'h0, srcs[i]});
		end
		// enable bit changed by read-modify-write, reserved bits written back as read
		rdx(`SCSD_IDX_OSC_CTRL, 1, 32'h0F);
		wr(`SCSD_IDX_OSC_CTRL, rd[7:0] | 8'h80);
		int_osc_settled <= 1;
		rdx(`SCSD_IDX_OSC_CTRL, 1, 32'hCF);
		check(internal_osc_on, 1);
		wr(`SCSD_IDX_OSC_CTRL, rd[7:0] & 8'h7F);
		rdx(`SCSD_IDX_OSC_CTRL, 1, 32'h0F);
		check(internal_osc_on, 0);
		// calibration and dither from a random value
		// trim kept up to 31 steps above the factory value, inside the usable band
		rd = {24'h0, 1'($random(seed)), 7'(`SCSD_CAL_FACTORY + ($random(seed) & 32'h1F))};
		wr(`SCSD_IDX_OSC_CAL, rd[7:0]);
		rdx(`SCSD_IDX_OSC_CAL, 1, rd);
		check({spread_dither_on, osc_trim}, rd[7:0]);
		// every external mode with the detector reporting stable
		ext_osc_stable <= 1;
		for (int m = 0; m < 8; m++)
		begin
			wr(`SCSD_IDX_EXT_CTRL, {1'b1, 3'(m), 1'b0, 3'(m + 3)});
			rdx(`SCSD_IDX_EXT_CTRL, 1, {24'h0, m >= 4 && m <= 6, 3'(m), 1'b0, 3'(m + 3)});
			check({ext_mode, ext_bias}, {3'(m), 3'(m + 3)});
		end
		// unmapped place reads zero
		wr(8'h10, 8'h5A);
		rdx(8'h10, 1, 32'h0);
		wrap_up;
	end
endmodule : tb_system_clock_select_divider
